// [pkg/strap_csr_pkg.sv]
// Constants for the supervisor trap and interrupt register block
package strap_csr_pkg;
  localparam int XLEN = 32;
  typedef logic [XLEN-1:0] word_t;
  typedef logic [11:0]     csr_addr_t;
  typedef logic [1:0]      csr_op_t;

  // Register addresses in the CSR space
  localparam csr_addr_t ADDR_SUP_IRQ_ENABLE   = 12'h104;
  localparam csr_addr_t ADDR_SUP_TRAP_VECTOR  = 12'h105;
  localparam csr_addr_t ADDR_SUP_SCRATCH      = 12'h140;
  localparam csr_addr_t ADDR_SUP_EXCEPTION_PC = 12'h141;
  localparam csr_addr_t ADDR_SUP_IRQ_PENDING  = 12'h144;

  // CSR operations
  localparam csr_op_t OP_WRITE = 2'h1;
  localparam csr_op_t OP_SET   = 2'h2;
  localparam csr_op_t OP_CLEAR = 2'h3;

  // Interrupt bit positions, shared by pending and enable
  localparam int BIT_USR_SOFT  = 0;
  localparam int BIT_SUP_SOFT  = 1;
  localparam int BIT_USR_TIMER = 4;
  localparam int BIT_SUP_TIMER = 5;
  localparam int BIT_USR_EXT   = 8;
  localparam int BIT_SUP_EXT   = 9;
  localparam int NUM_IRQ       = 10;

  localparam word_t IRQ_ALL_MASK = 32'h0000_0333;
  localparam word_t IRQ_USR_MASK = 32'h0000_0111;
  localparam word_t PEND_SW_MASK = 32'h0000_0103;

  // Trap vector mode field
  localparam int    MODE_W          = 2;
  localparam logic [1:0] MODE_DIRECT   = 2'h0;
  localparam logic [1:0] MODE_VECTORED = 2'h1;
  localparam int    CAUSE_SHIFT     = 2;

  localparam word_t RESET_VALUE = 32'h0000_0000;
  localparam word_t EPC_MASK_C  = 32'hffff_fffe;
  localparam word_t EPC_MASK_NC = 32'hffff_fffc;
endpackage

// [logic/sup_trap_csrs.sv]
// Supervisor interrupt, trap-vector, scratch and exception-PC registers
//
// Overview of operation
// RQ1: Pending/enable registers, bits 9,8,5,4,1,0 used.
// RQ2: Software writes raise/clear supervisor soft pending.
// RQ3: Software writes raise/clear user soft pending.
// RQ4: No user interrupts: user soft bits zero.
// RQ5: Only three pending bits writable by software.
// RQ6: Supervisor timer pending gated by its enable.
// RQ7: User timer gated; zero without user interrupts.
// RQ8: Supervisor external pending gated by its enable.
// RQ9: User external request ORs software and controller.
// RQ10: Read returns OR of user external sources.
// RQ11: Set/clear modify only software user external bit.
// RQ12: User external gated; zero without user interrupts.
// RQ13: Vector base 4-byte aligned, mode in bits 1:0.
// RQ14: Mode 0 direct, 1 vectored, others rejected.
// RQ15: Direct mode: every trap goes to base.
// RQ16: Vectored interrupts go to base plus 4*cause.
// RQ17: Scratch register is plain read/write storage.
// RQ18: Exception PC bit 0 (or 1:0) reads zero.
// RQ19: Trap loads exception PC with faulting address.
// RQ20: Supervisor mode global enable clear blocks interrupts.
// RQ21: Interrupt offered only when pending and enabled.
`timescale 1ns/1ps
module sup_trap_csrs
  import strap_csr_pkg::*;
#(
  parameter bit USER_IRQ_EN = 1'b1,
  parameter bit COMPRESSED  = 1'b1
)
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RESETN,
  input  wire logic                     CSR_EN,
  input  wire strap_csr_pkg::csr_op_t   CSR_OP,
  input  wire strap_csr_pkg::csr_addr_t CSR_ADDR,
  input  wire strap_csr_pkg::word_t     CSR_WDATA,
  output      strap_csr_pkg::word_t     CSR_RDATA,
  output      logic                     CSR_HIT,
  input  wire logic                     SUP_TIMER_IRQ,
  input  wire logic                     SUP_EXT_IRQ,
  input  wire logic                     USR_TIMER_IRQ,
  input  wire logic                     USR_EXT_IRQ,
  input  wire logic                     SUP_MODE,
  input  wire logic                     USR_MODE,
  input  wire logic                     SUP_GLOBAL_IE,
  input  wire logic                     USR_GLOBAL_IE,
  input  wire logic                     TRAP_TAKEN,
  input  wire logic                     TRAP_IS_IRQ,
  input  wire logic [3:0]               TRAP_CAUSE,
  input  wire strap_csr_pkg::word_t     TRAP_PC,
  output      strap_csr_pkg::word_t     TRAP_TARGET,
  output      strap_csr_pkg::word_t     IRQ_REQUEST,
  output      logic                     IRQ_ANY
);
  import strap_csr_pkg::*;

  localparam word_t USR_KEEP = USER_IRQ_EN ? IRQ_ALL_MASK
                                           : (IRQ_ALL_MASK & ~IRQ_USR_MASK);
  localparam word_t EPC_MASK = COMPRESSED ? EPC_MASK_C : EPC_MASK_NC;

  function automatic word_t rmw(input csr_op_t op, input word_t old,
                                input word_t opnd);
    unique case (op)
      OP_SET:   rmw = old | opnd;
      OP_CLEAR: rmw = old & ~opnd;
      default:  rmw = opnd;
    endcase
  endfunction

  // Synchronised interrupt lines from the platform
  logic [3:0] irq_meta_r;
  logic [3:0] irq_sync_r;

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
    begin
      irq_meta_r <= 4'h0;
      irq_sync_r <= 4'h0;
    end
    else
    begin
      irq_meta_r <= {USR_EXT_IRQ, USR_TIMER_IRQ, SUP_EXT_IRQ, SUP_TIMER_IRQ};
      irq_sync_r <= irq_meta_r;
    end

  word_t pend_sw_r;
  word_t enable_r;
  word_t tvec_r;
  word_t scratch_r;
  word_t epc_r;
  word_t pend_view;

  // Software bits plus hardware sources; user bits vanish if unsupported
  always_comb
  begin
    pend_view = pend_sw_r & PEND_SW_MASK;                          // RQ5
    pend_view[BIT_SUP_TIMER] = irq_sync_r[0];                      // RQ6
    pend_view[BIT_SUP_EXT]   = irq_sync_r[1];                      // RQ8
    pend_view[BIT_USR_TIMER] = irq_sync_r[2];                      // RQ7
    pend_view[BIT_USR_EXT]   = pend_sw_r[BIT_USR_EXT] | irq_sync_r[3]; // RQ9
    pend_view = pend_view & USR_KEEP;                              // RQ4 RQ12
  end

  logic wr_pend;
  logic wr_en;
  logic wr_tvec;
  logic wr_scr;
  logic wr_epc;
  assign wr_pend = CSR_EN && CSR_ADDR == ADDR_SUP_IRQ_PENDING;
  assign wr_en   = CSR_EN && CSR_ADDR == ADDR_SUP_IRQ_ENABLE;
  assign wr_tvec = CSR_EN && CSR_ADDR == ADDR_SUP_TRAP_VECTOR;
  assign wr_scr  = CSR_EN && CSR_ADDR == ADDR_SUP_SCRATCH;
  assign wr_epc  = CSR_EN && CSR_ADDR == ADDR_SUP_EXCEPTION_PC;

  // Read-modify-write uses the stored software bit, not the OR
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      pend_sw_r <= RESET_VALUE;
    else if (wr_pend)
      pend_sw_r <= rmw(CSR_OP, pend_sw_r, CSR_WDATA)
                   & PEND_SW_MASK & USR_KEEP;              // RQ2 RQ3 RQ5 RQ11

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      enable_r <= RESET_VALUE;
    else if (wr_en)
      enable_r <= rmw(CSR_OP, enable_r, CSR_WDATA) & USR_KEEP; // RQ1 RQ4

  // Reserved mode values leave the old mode in place
  word_t tvec_nxt;
  always_comb
  begin
    tvec_nxt = rmw(CSR_OP, tvec_r, CSR_WDATA);
    if (tvec_nxt[MODE_W-1:0] != MODE_DIRECT
        && tvec_nxt[MODE_W-1:0] != MODE_VECTORED)                 // RQ14
      tvec_nxt[MODE_W-1:0] = tvec_r[MODE_W-1:0];
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      tvec_r <= RESET_VALUE;
    else if (wr_tvec)
      tvec_r <= tvec_nxt;                                         // RQ13

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      scratch_r <= RESET_VALUE;
    else if (wr_scr)
      scratch_r <= rmw(CSR_OP, scratch_r, CSR_WDATA);             // RQ17

  // Trap capture beats a software write in the same cycle
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      epc_r <= RESET_VALUE;
    else if (TRAP_TAKEN)
      epc_r <= TRAP_PC & EPC_MASK;                                // RQ19 RQ18
    else if (wr_epc)
      epc_r <= rmw(CSR_OP, epc_r, CSR_WDATA) & EPC_MASK;          // RQ18

  // Read port, registered
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
    begin
      CSR_RDATA <= RESET_VALUE;
      CSR_HIT   <= 1'b0;
    end
    else
    begin
      CSR_HIT <= CSR_EN && (wr_pend || wr_en || wr_tvec || wr_scr || wr_epc);
      unique case (1'b1)
        wr_pend: CSR_RDATA <= pend_view;                          // RQ10
        wr_en:   CSR_RDATA <= enable_r;
        wr_tvec: CSR_RDATA <= tvec_r;
        wr_scr:  CSR_RDATA <= scratch_r;
        wr_epc:  CSR_RDATA <= epc_r;
        default: CSR_RDATA <= RESET_VALUE;
      endcase
    end

  // Global enable: user mode always lets supervisor interrupts through
  logic  sup_ok;
  logic  usr_ok;
  word_t req_nxt;
  assign sup_ok = USR_MODE || (SUP_MODE && SUP_GLOBAL_IE);        // RQ20
  assign usr_ok = USR_MODE && USR_GLOBAL_IE;

  always_comb
  begin
    req_nxt = pend_view & enable_r;                   // RQ21 RQ2 RQ3 RQ6 RQ8
    if (!sup_ok)
      req_nxt = req_nxt & IRQ_USR_MASK;
    if (!usr_ok)
      req_nxt = req_nxt & ~IRQ_USR_MASK;                          // RQ7 RQ12
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
    begin
      IRQ_REQUEST <= RESET_VALUE;
      IRQ_ANY     <= 1'b0;
    end
    else
    begin
      IRQ_REQUEST <= req_nxt;
      IRQ_ANY     <= |req_nxt;
    end

  // Trap target follows the current vector setting
  word_t base;
  word_t vec_off;
  assign base    = {tvec_r[XLEN-1:MODE_W], {MODE_W{1'b0}}};
  assign vec_off = word_t'(TRAP_CAUSE) << CAUSE_SHIFT;

  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      TRAP_TARGET <= RESET_VALUE;
    else if (tvec_r[MODE_W-1:0] == MODE_VECTORED && TRAP_IS_IRQ)
      TRAP_TARGET <= base + vec_off;                              // RQ16
    else
      TRAP_TARGET <= base;                                        // RQ15
endmodule

// [tb/irq_src_model.sv]
// Interrupt controller and timer source model
`timescale 1ns/1ps
module irq_src_model (
  input  wire logic       clk,
  input  wire logic [3:0] lvl,
  output logic      [3:0] pins
);
  // Levels move just after an edge, as a registered source would
  always_ff @(posedge clk) pins <= lvl;
endmodule

// [tb/strap_chk_sva.sv]
// Port assertions for the supervisor trap register block
`timescale 1ns/1ps
module strap_chk
  import strap_csr_pkg::*;
(
  input wire logic                     CORE_CLK,
  input wire logic                     RESETN,
  input wire logic                     CSR_EN,
  input wire strap_csr_pkg::csr_op_t   CSR_OP,
  input wire strap_csr_pkg::csr_addr_t CSR_ADDR,
  input wire strap_csr_pkg::word_t     CSR_WDATA,
  input wire strap_csr_pkg::word_t     CSR_RDATA,
  input wire logic                     CSR_HIT,
  input wire logic                     TRAP_TAKEN,
  input wire strap_csr_pkg::word_t     TRAP_PC,
  input wire strap_csr_pkg::word_t     IRQ_REQUEST,
  input wire logic                     IRQ_ANY
);
  logic scr, vec, pnd, wr;
  assign scr = CSR_EN && CSR_ADDR == ADDR_SUP_SCRATCH;
  assign vec = CSR_EN && CSR_ADDR == ADDR_SUP_TRAP_VECTOR;
  assign pnd = CSR_EN && CSR_ADDR == ADDR_SUP_IRQ_PENDING;
  assign wr  = CSR_OP == OP_WRITE;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  property p_req_rsv;
    (IRQ_REQUEST & ~IRQ_ALL_MASK) == '0;
  endproperty
  property p_pnd_rsv;
    CSR_HIT && $past(CSR_ADDR) == ADDR_SUP_IRQ_PENDING
      |-> (CSR_RDATA & ~IRQ_ALL_MASK) == '0;
  endproperty
  property p_scr;
    scr && wr ##1 scr |=> CSR_RDATA == $past(CSR_WDATA, 2);
  endproperty
  property p_sup_soft_pending;
    pnd && wr ##1 pnd |=> CSR_RDATA[1] == $past(CSR_WDATA[1], 2);
  endproperty
  property p_usr_soft_pending;
    pnd && wr ##1 pnd |=> CSR_RDATA[0] == $past(CSR_WDATA[0], 2);
  endproperty
  property p_vbase;
    vec && wr ##1 vec |=> CSR_RDATA[31:2] == $past(CSR_WDATA[31:2], 2);
  endproperty
  property p_vmode;
    CSR_HIT && $past(CSR_ADDR) == ADDR_SUP_TRAP_VECTOR |-> !CSR_RDATA[1];
  endproperty
  property p_epc;
    TRAP_TAKEN ##1 CSR_EN && CSR_ADDR == ADDR_SUP_EXCEPTION_PC && !TRAP_TAKEN
      |=> CSR_RDATA == ($past(TRAP_PC, 2) & EPC_MASK_C);
  endproperty
  a_req_rsv: assert property (p_req_rsv) else $error("reserved req");
  a_pnd_rsv: assert property (p_pnd_rsv) else $error("pending ro");
  a_scr: assert property (p_scr) else $error("scratch lost");
  a_sup_soft_pending: assert property (p_sup_soft_pending) else $error("sup soft bit");
  a_usr_soft_pending: assert property (p_usr_soft_pending) else $error("usr soft bit");
  a_vbase: assert property (p_vbase) else $error("vector base");
  a_vmode: assert property (p_vmode) else $error("vector mode");
  a_epc: assert property (p_epc) else $error("exception pc");
  c_trap: cover property (TRAP_TAKEN ##1 CSR_EN);
  c_any: cover property (IRQ_ANY);
  c_pnd: cover property (pnd ##1 CSR_HIT);
endmodule
bind sup_trap_csrs strap_chk u_chk (.*);

// [tb/tb.sv]
// Self-checking bench for the supervisor trap register block
`timescale 1ns/1ps
module tb;
  import strap_csr_pkg::*;
  logic CORE_CLK = 0, RESETN = 0, CSR_EN = 0, TRAP_TAKEN = 0, TRAP_IS_IRQ = 0;
  logic SUP_MODE = 0, USR_MODE = 1, SUP_GLOBAL_IE = 0, USR_GLOBAL_IE = 1;
  logic [3:0]  TRAP_CAUSE = '0, lvl = '0;
  csr_op_t     CSR_OP = OP_WRITE;
  csr_addr_t   CSR_ADDR = '0;
  word_t       CSR_WDATA = '0, TRAP_PC = '0;
  word_t       CSR_RDATA, TRAP_TARGET, IRQ_REQUEST;
  logic        CSR_HIT, IRQ_ANY, pend = 0;
  logic [32:0] pexp;
  wire logic   SUP_TIMER_IRQ, SUP_EXT_IRQ, USR_TIMER_IRQ, USR_EXT_IRQ;
  int          err_count = 0, total_checks = 0, cyc = 0;
  sup_trap_csrs uut (.*);
  irq_src_model u_src (.clk(CORE_CLK), .lvl(lvl),
    .pins({USR_EXT_IRQ, USR_TIMER_IRQ, SUP_EXT_IRQ, SUP_TIMER_IRQ}));
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [32:0] got, logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Result stands one cycle, so it is compared at the following low phase
  task automatic acc(csr_op_t op, csr_addr_t a, word_t d, word_t e);
    CSR_EN <= 1;
    CSR_OP <= op;
    CSR_ADDR <= a;
    CSR_WDATA <= d;
    @(posedge CORE_CLK);
    pexp = {a != 12'h7ff, e};
    pend = 1;
  endtask
  task automatic idle(int n);
    CSR_EN <= 0;
    repeat (n) @(posedge CORE_CLK);
  endtask
  initial forever #5 CORE_CLK = ~CORE_CLK;
  always @(negedge CORE_CLK)
    if (pend)
    begin
      chk({CSR_HIT, CSR_RDATA}, pexp);
      pend = 0;
    end
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    RESETN <= 1;
    acc(OP_WRITE, ADDR_SUP_SCRATCH, 32'ha5a5_0f0f, '0);
    acc(OP_SET, ADDR_SUP_SCRATCH, '0, 32'ha5a5_0f0f);
    acc(OP_WRITE, 12'h7ff, 32'hffff_ffff, '0);
    acc(OP_SET, ADDR_SUP_SCRATCH, '0, 32'ha5a5_0f0f);
    acc(OP_WRITE, ADDR_SUP_IRQ_PENDING, 32'hffff_ffff, '0);
    acc(OP_CLEAR, ADDR_SUP_IRQ_PENDING, 32'h2, 32'h103);
    acc(OP_CLEAR, ADDR_SUP_IRQ_PENDING, 32'h1, 32'h101);
    acc(OP_WRITE, ADDR_SUP_IRQ_ENABLE, 32'hffff_ffff, '0);
    acc(OP_SET, ADDR_SUP_IRQ_ENABLE, '0, 32'h333);
    idle(6);
    chk({IRQ_ANY, IRQ_REQUEST}, {1'b1, 32'h100});
    lvl <= 4'hf;
    idle(6);
    chk({IRQ_ANY, IRQ_REQUEST}, {1'b1, 32'h330});
    acc(OP_CLEAR, ADDR_SUP_IRQ_ENABLE, 32'h220, 32'h333);
    idle(6);
    chk({IRQ_ANY, IRQ_REQUEST}, {1'b1, 32'h110});
    acc(OP_CLEAR, ADDR_SUP_IRQ_PENDING, 32'h100, 32'h330);
    acc(OP_SET, ADDR_SUP_IRQ_PENDING, '0, 32'h330);
    lvl <= 4'h3;
    idle(5);
    acc(OP_SET, ADDR_SUP_IRQ_PENDING, '0, 32'h220);
    acc(OP_WRITE, ADDR_SUP_IRQ_ENABLE, 32'h333, 32'h113);
    SUP_MODE <= 1;
    USR_MODE <= 0;
    idle(4);
    chk({IRQ_ANY, IRQ_REQUEST}, {1'b0, 32'h0});
    SUP_GLOBAL_IE <= 1;
    idle(4);
    chk({IRQ_ANY, IRQ_REQUEST}, {1'b1, 32'h220});
    acc(OP_WRITE, ADDR_SUP_TRAP_VECTOR, 32'h1000_0001, '0);
    acc(OP_WRITE, ADDR_SUP_TRAP_VECTOR, 32'h2000_0002, 32'h1000_0001);
    acc(OP_SET, ADDR_SUP_TRAP_VECTOR, '0, 32'h2000_0001);
    TRAP_IS_IRQ <= 1;
    TRAP_CAUSE <= 4'h5;
    idle(3);
    chk({1'b0, TRAP_TARGET}, {1'b0, 32'h2000_0014});
    TRAP_IS_IRQ <= 0;
    idle(3);
    chk({1'b0, TRAP_TARGET}, {1'b0, 32'h2000_0000});
    acc(OP_WRITE, ADDR_SUP_TRAP_VECTOR, 32'h3000_0000, 32'h2000_0001);
    TRAP_IS_IRQ <= 1;
    idle(3);
    chk({1'b0, TRAP_TARGET}, {1'b0, 32'h3000_0000});
    TRAP_PC <= 32'h8000_0003;
    TRAP_TAKEN <= 1;
    @(posedge CORE_CLK);
    TRAP_TAKEN <= 0;
    acc(OP_WRITE, ADDR_SUP_EXCEPTION_PC, 32'hffff_ffff, 32'h8000_0002);
    acc(OP_SET, ADDR_SUP_EXCEPTION_PC, '0, 32'hffff_fffe);
    idle(2);
    close_out();
  end
endmodule
